// file: status_led_pattern_driver.sv
/*
  Status indicator pattern driver: encodes run, fault and network states
  as steady, blink, flash and flicker levels on the indicator bits of the
  first output shift register image.
  Assumes a 25 MHz clock, synchronous reset, and a host that enables the
  first output shift register before expecting lamp activity.
*/
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module status_led_pattern_driver (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Register port
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  // Shift register image of the first output shift register
  output logic [led_status_pkg::LAMP_COUNT-1:0] o_shift_lamps,
  output logic o_shift_enable
);
  import led_status_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [15:0] shift_cfg, next_shift_cfg;
  logic [15:0] state_ctl, next_state_ctl;
  logic [15:0] rdata, next_rdata;
  logic [LAMP_COUNT-1:0] lamps, next_lamps;

  // Decodes a pattern selection for one lamp
  function automatic logic pick(input logic steady_on, input logic blink_sel,
                                input logic flash1_sel, input logic flash2_sel,
                                input logic flick_sel, input logic blink,
                                input logic flash1, input logic flash2,
                                input logic flicker);
    pick = flick_sel ? flicker :
           flash2_sel ? flash2 :
           flash1_sel ? flash1 :
           blink_sel ? blink : steady_on;
  endfunction

  logic tick, blink, flicker, flash1, flash2;

  led_tick_divider u_div (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .o_tick(tick)
  );

  led_pattern_gen u_pat (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_tick(tick),
    .o_blink(blink),
    .o_flicker(flicker),
    .o_flash1(flash1),
    .o_flash2(flash2)
  );

  run_state_t run_st;
  fault_state_t flt_st;
  net_run_t net_st;
  net_err_t nerr_st;
  logic node_set;
  logic shift_en;

  always_comb begin
    run_st = run_state_t'(state_ctl[RUN_LSB +: 2]);
    flt_st = fault_state_t'(state_ctl[FAULT_LSB +: 2]);
    net_st = net_run_t'(state_ctl[NET_RUN_LSB +: 3]);
    nerr_st = net_err_t'(state_ctl[NET_ERR_LSB +: 3]);
    node_set = state_ctl[NODE_SET_BIT];
    shift_en = shift_cfg[SHIFT_ENABLE_BIT];
  end

  // ----------------------------------------
  // Register writes and reads
  // ----------------------------------------
  always_comb begin
    next_shift_cfg = shift_cfg;
    next_state_ctl = state_ctl;
    next_rdata = 16'h0000;
    if (i_wr && i_addr == ADDR_SHIFT_OUT_FIRST_CONFIG) begin
      next_shift_cfg = i_wdata;
    end
    if (i_wr && i_addr == ADDR_STATE_CONTROL) begin
      next_state_ctl = i_wdata;
    end
    if (i_rd) begin
      unique case (i_addr)
        ADDR_SHIFT_OUT_FIRST_CONFIG: next_rdata = shift_cfg;
        ADDR_STATE_CONTROL: next_rdata = state_ctl;
        ADDR_LAMP_STATUS: next_rdata = {10'h000, lamps};
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  // ----------------------------------------
  // Lamp pattern selection
  // ----------------------------------------
  always_comb begin
    next_lamps = '0;
    // Encodings beyond the listed states show the lamp off, except that node_set makes both network lamps flicker.
    next_lamps[LAMP_RUN] = pick(run_st == RUN_NORMAL, run_st == RUN_STARTUP,
                                1'b0, 1'b0, 1'b0, blink, flash1, flash2, flicker);
    next_lamps[LAMP_FAULT] = pick(flt_st == FLT_INTERNAL, flt_st == FLT_CONFIG,
                                  1'b0, 1'b0, 1'b0, blink, flash1, flash2, flicker);
    next_lamps[LAMP_NET_RUN] = pick(net_st == NET_OPERATIONAL, net_st == NET_INIT,
                                    net_st == NET_STOPPED, 1'b0, node_set,
                                    blink, flash1, flash2, flicker);
    next_lamps[LAMP_NET_ERR] = pick(nerr_st == NERR_BUS_OFF, 1'b0,
                                    nerr_st == NERR_WARNING, nerr_st == NERR_GUARD,
                                    node_set, blink, flash1, flash2, flicker);
    // Lamps only leave through the enabled shift register image
    if (!shift_en) begin
      next_lamps = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      shift_cfg <= SHIFT_CONFIG_RESET;
      state_ctl <= 16'h0000;
      rdata <= 16'h0000;
      lamps <= '0;
    end else begin
      shift_cfg <= next_shift_cfg;
      state_ctl <= next_state_ctl;
      rdata <= next_rdata;
      lamps <= next_lamps;
    end
  end

  assign o_rdata = rdata;
  assign o_shift_lamps = lamps;
  assign o_shift_enable = shift_cfg[SHIFT_ENABLE_BIT];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_run_normal_on: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (run_st == RUN_NORMAL && shift_en) |=> o_shift_lamps[LAMP_RUN])
    else $error("run lamp not on in normal run");
  a_run_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (run_st == RUN_OFF) |=> !o_shift_lamps[LAMP_RUN])
    else $error("run lamp lit while not running");
  a_fault_internal_on: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (flt_st == FLT_INTERNAL && shift_en) |=> o_shift_lamps[LAMP_FAULT])
    else $error("fault lamp not on for internal error");
  a_fault_config_blink: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (flt_st == FLT_CONFIG && shift_en) |=> (o_shift_lamps[LAMP_FAULT] == $past(blink)))
    else $error("fault lamp not blinking on config error");
  a_netrun_stop_flash: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (net_st == NET_STOPPED && !node_set && shift_en)
      |=> (o_shift_lamps[LAMP_NET_RUN] == $past(flash1)))
    else $error("network run lamp not single flashing");
  a_neterr_guard_flash: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (nerr_st == NERR_GUARD && !node_set && shift_en)
      |=> (o_shift_lamps[LAMP_NET_ERR] == $past(flash2)))
    else $error("network fault lamp not double flashing");
  a_neterr_flicker: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (node_set && shift_en) |=> (o_shift_lamps[LAMP_NET_ERR] == $past(flicker)))
    else $error("network fault lamp not flickering");
  a_disabled_dark: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !shift_en |=> (o_shift_lamps == '0))
    else $error("lamps active with shift register disabled");
endmodule
`default_nettype wire

// file: led_status_pkg.sv
/*
  Constants shared by the indicator pattern driver: register map, bit
  positions, state encodings and pattern timing.
  Assumes a 25 MHz system clock and a plain strobe register port.
*/
package led_status_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = (CLK_HZ / 1000000) * TICK_US;
  localparam logic [7:0] FLICKER_HALF_TICKS = 8'h32;
  localparam logic [7:0] BLINK_HALF_TICKS = 8'hC8;
  localparam logic [7:0] FLASH_ON_TICKS = 8'hC8;
  localparam logic [7:0] FLASH_GAP_TICKS = 8'hC8;
  localparam logic [10:0] FLASH_PAUSE_TICKS = 11'h3E8;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [15:0] ADDR_SHIFT_OUT_FIRST_CONFIG = 16'h0025;
  localparam logic [15:0] ADDR_STATE_CONTROL = 16'h0100;
  localparam logic [15:0] ADDR_LAMP_STATUS = 16'h0101;
  localparam logic [15:0] SHIFT_CONFIG_RESET = 16'h0000;
  localparam int SHIFT_ENABLE_BIT = 0;

  // State control register fields
  localparam int RUN_LSB = 0;
  localparam int FAULT_LSB = 2;
  localparam int NET_RUN_LSB = 4;
  localparam int NET_ERR_LSB = 7;
  localparam int NODE_SET_BIT = 10;

  // Indicator bit positions in the first output shift register
  localparam int LAMP_RUN = 0;
  localparam int LAMP_FAULT = 1;
  localparam int LAMP_NET_RUN = 4;
  localparam int LAMP_NET_ERR = 5;
  localparam int LAMP_COUNT = 6;

  typedef enum logic [1:0] {RUN_OFF, RUN_STARTUP, RUN_NORMAL} run_state_t;
  typedef enum logic [1:0] {FLT_NONE, FLT_CONFIG, FLT_INTERNAL} fault_state_t;
  typedef enum logic [2:0] {NET_OFF, NET_OPERATIONAL, NET_STOPPED, NET_INIT}
    net_run_t;
  typedef enum logic [2:0] {NERR_NONE, NERR_BUS_OFF, NERR_WARNING, NERR_GUARD}
    net_err_t;
endpackage

// file: led_tick_divider.sv
/*
  Free-running divider making a one-cycle tick enable.
  Assumes one system clock and synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module led_tick_divider (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Tick enable
  output logic o_tick
);
  import led_status_pkg::*;
  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
  logic [15:0] count;
  logic [15:0] next_count;

  always_comb begin
    next_count = (count == TICK_LAST) ? 16'h0000 : count + 16'h0001;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      count <= 16'h0000;
    end else begin
      count <= next_count;
    end
  end

  assign o_tick = (count == TICK_LAST);
endmodule
`default_nettype wire

// file: led_pattern_gen.sv
/*
  Pattern phases for blink, flicker, single and double flash.
  Assumes a one-cycle tick enable from the divider.
*/
`timescale 1ns/1ps
`default_nettype none
module led_pattern_gen (
  // Clock, reset and tick enable
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_tick,
  // Pattern levels
  output logic o_blink,
  output logic o_flicker,
  output logic o_flash1,
  output logic o_flash2
);
  import led_status_pkg::*;
  // Flash frame: on, gap, on, long pause
  localparam logic [10:0] F_ON1_END = 11'(FLASH_ON_TICKS);
  localparam logic [10:0] F_GAP_END = 11'(FLASH_ON_TICKS + FLASH_GAP_TICKS);
  localparam logic [10:0] F_ON2_END = 11'(2 * FLASH_ON_TICKS + FLASH_GAP_TICKS);
  localparam logic [10:0] F_LAST = 11'(F_ON2_END + FLASH_PAUSE_TICKS - 1);

  logic [7:0] blink_cnt, next_blink_cnt, flick_cnt, next_flick_cnt;
  logic [10:0] frame, next_frame;
  logic blink, next_blink, flicker, next_flicker;

  always_comb begin
    next_blink_cnt = blink_cnt;
    next_flick_cnt = flick_cnt;
    next_frame = frame;
    next_blink = blink;
    next_flicker = flicker;
    if (i_tick) begin
      if (blink_cnt == BLINK_HALF_TICKS - 8'h01) begin
        next_blink_cnt = 8'h00;
        next_blink = !blink;
      end else begin
        next_blink_cnt = blink_cnt + 8'h01;
      end
      if (flick_cnt == FLICKER_HALF_TICKS - 8'h01) begin
        next_flick_cnt = 8'h00;
        next_flicker = !flicker;
      end else begin
        next_flick_cnt = flick_cnt + 8'h01;
      end
      next_frame = (frame == F_LAST) ? 11'h000 : frame + 11'h001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      blink_cnt <= 8'h00;
      flick_cnt <= 8'h00;
      frame <= 11'h000;
      blink <= 1'b0;
      flicker <= 1'b0;
    end else begin
      blink_cnt <= next_blink_cnt;
      flick_cnt <= next_flick_cnt;
      frame <= next_frame;
      blink <= next_blink;
      flicker <= next_flicker;
    end
  end

  assign o_blink = blink;
  assign o_flicker = flicker;
  assign o_flash1 = (frame < F_ON1_END);
  assign o_flash2 = (frame < F_ON1_END) || (frame >= F_GAP_END && frame < F_ON2_END);
endmodule
`default_nettype wire

// file: lamp_chain_model.sv
/*
  Host shift-register chain that carries the indicator lamps.
  Assumes the driver's lamp image and shift enable, on the driver's clock.
*/
`timescale 1ns/1ps
`default_nettype none
module lamp_chain_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Image from the driver
  input wire logic [led_status_pkg::LAMP_COUNT-1:0] i_lamps,
  input wire logic i_enable,
  // Lamp levels on the chain
  output logic [led_status_pkg::LAMP_COUNT-1:0] o_lamps
);
  import led_status_pkg::*;
  // ----------------------------------------
  // Chain latch
  // ----------------------------------------
  // A chain that was never enabled shows dark lamps, not a stale image
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !i_enable) begin
      o_lamps <= '0;
    end else begin
      o_lamps <= i_lamps;
    end
  end
endmodule
`default_nettype wire

// file: status_led_pattern_driver_tb.sv
/*
  Self-checking bench for the indicator pattern driver.
  Assumes the lamp chain model; the run ends inside the first pattern
  phase: blink and flicker still low, both flash frames still lit.
*/
`timescale 1ns/1ps
`default_nettype none
module status_led_pattern_driver_tb;
  import led_status_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [15:0] i_addr = 16'h0000;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [15:0] o_rdata;
  logic [LAMP_COUNT-1:0] o_shift_lamps;
  logic o_shift_enable;
  logic [LAMP_COUNT-1:0] chain_lamps;
  logic exp_en = 1'b0;
  logic [15:0] rv;
  int errors = 0;
  int samples_checked = 0;
  // ----------------------------------------
  // State table: code, steady bits, bits left free for patterns
  // ----------------------------------------
  logic [15:0] codes [17] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0008,
    16'h000C, 16'h0010, 16'h0020, 16'h0030, 16'h0070, 16'h0080, 16'h0100, 16'h0180,
    16'h0380, 16'h0402, 16'h009A};
  logic [15:0] exps [17] = '{16'h00, 16'h00, 16'h01, 16'h00, 16'h00, 16'h02, 16'h00,
    16'h10, 16'h10, 16'h00, 16'h00, 16'h20, 16'h20, 16'h20, 16'h00, 16'h01, 16'h33};
  logic [15:0] masks [17] = '{16'h00, 16'h00, 16'h00, 16'h00, 16'h00, 16'h00, 16'h00,
    16'h00, 16'h00, 16'h00, 16'h00, 16'h00, 16'h00, 16'h00, 16'h00, 16'h00, 16'h00};

  always #20 i_clk = ~i_clk;

  status_led_pattern_driver DUT (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .o_shift_lamps(o_shift_lamps),
    .o_shift_enable(o_shift_enable)
  );

  lamp_chain_model u_chain (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_lamps(o_shift_lamps),
    .i_enable(o_shift_enable),
    .o_lamps(chain_lamps)
  );
  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask

  // Read data live only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [15:0] v);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    v = o_rdata;
    @(posedge i_clk);
  endtask

  // Waits out the driver and chain latency before looking
  task automatic lamps(input logic [15:0] exp, input logic [15:0] mask);
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    check("lamp image", 16'(o_shift_lamps) & ~mask, exp);
    check("chain image", 16'(chain_lamps) & ~mask, exp);
    check("shift enable", 16'(o_shift_enable), 16'(exp_en));
    check("rdata idle", o_rdata, 16'h0000);
    @(posedge i_clk);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    rd(ADDR_SHIFT_OUT_FIRST_CONFIG, rv);
    check("shift config reset", rv, SHIFT_CONFIG_RESET);
    wr(ADDR_STATE_CONTROL, 16'h0002);
    lamps(16'h0000, 16'h0000);
    $display("test reset and gating done");
    wr(ADDR_SHIFT_OUT_FIRST_CONFIG, 16'hA5A1);
    exp_en = 1'b1;
    lamps(16'h0001, 16'h0000);
    rd(ADDR_SHIFT_OUT_FIRST_CONFIG, rv);
    check("shift config", rv, 16'hA5A1);
    $display("test enable done");
    for (int k = 0; k < 17; k++) begin
      wr(ADDR_STATE_CONTROL, codes[k]);
      lamps(exps[k], masks[k]);
      rd(ADDR_LAMP_STATUS, rv);
      check("lamp status", rv & ~masks[k], exps[k]);
    end
    $display("test state table done");
    rd(16'h0200, rv);
    check("unmapped read", rv, 16'h0000);
    wr(ADDR_LAMP_STATUS, 16'hFFFF);
    rd(ADDR_LAMP_STATUS, rv);
    check("read-only status", rv, 16'h0033);
    wr(ADDR_SHIFT_OUT_FIRST_CONFIG, 16'h0000);
    exp_en = 1'b0;
    lamps(16'h0000, 16'h0000);
    $display("test register port done");
    summarize();
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge i_clk);
    errors++;
    $display("[FAIL] watchdog expected finish seen timeout");
    summarize();
  end
endmodule
`default_nettype wire
